//--- common/sync_slave_pkg.sv
// Purpose: Shared constants for the synchronous slave serial port.
// Assumes: APB register access with 32-bit data, one register per aligned word.
// Notes: Offsets and field positions below are the block's fixed register map.
//
// Contract
// R1 - Slave when sync set, clock source clear, enabled
// R2 - Both receive enables clear means transmit, else receive
// R3 - First queued character moves straight into shifter
// R4 - Shifter empty: pending character loads, transmit flag sets
// R5 - Transmit flag with enables wakes the sleeping core
// R6 - Slave reception is continuous; single-receive bit ignored
// R7 - Character received in sleep reaches data register, wakes
// R8 - Only synchronous slave mode runs during sleep
// R9 - Shift registers advance only on the external clock
// R10 - Receive-complete flag sets after full word, wakes core
// R11 - After wake, interrupt vector is address 004h
// R12 - Sleep transmit: reload shifter, set flag, wake core
// R13 - Writing the holding register clears transmit flag
// R14 - Software drains receive buffer before sleeping
// R15 - Clearing continuous receive or port enable clears overrun
// R16 - Ninth transmit bit comes from the ninth-bit value
// R17 - Ninth received bit shown in receive status
// R18 - Clock pin driver disabled; clock taken from master
// R19 - Data changes on leading edge, sampled at trailing
// R20 - Two-character receive buffer; third sets overrun, dropped
// R21 - Characters shift least significant bit first

package sync_slave_pkg;

   // ------------------------------------------------------------------
   // Bus geometry and register offsets
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] TX_CTRL_OFF = 8'h00;
   localparam logic [7:0] RX_CTRL_OFF = 8'h04;
   localparam logic [7:0] BAUD_OFF = 8'h08;
   localparam logic [7:0] TX_HOLD_OFF = 8'h0c;
   localparam logic [7:0] RX_HOLD_OFF = 8'h10;
   localparam logic [7:0] INT_CTRL_OFF = 8'h14;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int TXC_CLK_SRC = 7;
   localparam int TXC_NINTH_EN = 6;
   localparam int TXC_TX_EN = 5;
   localparam int TXC_SYNC = 4;
   localparam int TXC_TRMT = 1;
   localparam int TXC_NINTH_VAL = 0;
   localparam int RXC_PORT_EN = 7;
   localparam int RXC_NINTH_EN = 6;
   localparam int RXC_SINGLE_EN = 5;
   localparam int RXC_CONT_EN = 4;
   localparam int RXC_OVERRUN = 1;
   localparam int RXC_NINTH_VAL = 0;
   localparam int BAUD_RXIDLE = 6;
   localparam int INT_TX_IE = 0;
   localparam int INT_RX_IE = 1;
   localparam int INT_PERIPH_IE = 2;
   localparam int INT_GLOBAL_IE = 3;
   localparam int INT_TX_READY = 4;
   localparam int INT_RX_DONE = 5;

   // ------------------------------------------------------------------
   // Reset values, counts and vector
   // ------------------------------------------------------------------
   localparam logic CTRL_RESET = 1'b0;
   localparam logic [3:0] BITS_PLAIN = 4'h8;
   localparam logic [3:0] BITS_NINTH = 4'h9;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   localparam logic [11:0] ISR_VECTOR = 12'h004;

   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_SHIFT = 1'b1
   } tx_state_t;

endpackage

//--- core/sync_slave_serial_port.sv
// Purpose: Synchronous slave serial port with APB registers and sleep wake-up.
// Assumes: Serial clock idles low; leading edge rising, trailing edge falling.
// Notes: Serial pins are sampled on pclk through two flip-flops each.

module sync_slave_serial_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sync_slave_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ck_in,
   output logic ck_out,
   output logic ck_oe,
   input wire logic dt_in,
   output logic dt_out,
   output logic dt_oe,
   input wire logic core_sleep,
   output logic wake,
   output logic irq,
   output logic [11:0] irq_vector
);
   import sync_slave_pkg::*;

   // Character length in bits for the ninth-bit enable.
   function automatic logic [3:0] char_bits(input logic ninth);
      char_bits = ninth ? BITS_NINTH : BITS_PLAIN;
   endfunction

   logic clk_src_q, tx9en_q, tx_en_q, sync_q, tx_ninth_q;
   logic port_en_q, rx9en_q, single_rx_q, cont_rx_q;
   logic tx_ie_q, rx_ie_q, periph_ie_q, global_ie_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic ck_meta_q, ck_sync_q, ck_prev_q, dt_meta_q, dt_sync_q;
   tx_state_t tx_state_q;
   logic [8:0] tx_shift_q;
   logic [3:0] tx_cnt_q, tx_len_q;
   logic [7:0] hold_q;
   logic hold_valid_q, dt_out_q, dt_oe_q, ck_out_q, ck_oe_q;
   logic [8:0] rx_shift_q;
   logic [3:0] rx_cnt_q;
   logic [8:0] fifo_q [2];
   logic head_q;
   logic [1:0] count_q;
   logic overrun_q, wake_q, irq_q;
   logic [11:0] vector_q;

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------
   logic slave_mode, rx_mode, tx_mode;
   assign slave_mode = sync_q & ~clk_src_q & port_en_q; // R1 R8
   assign rx_mode = slave_mode & (single_rx_q | cont_rx_q); // R2 R6
   assign tx_mode = slave_mode & ~single_rx_q & ~cont_rx_q & tx_en_q; // R2

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   logic access, done, wr, hit, rd_pop, hold_wr;
   logic [7:0] rd_d;
   logic tx_ready, rx_done;
   assign access = psel & penable;
   assign done = access & pready_q;
   assign wr = done & pwrite & pstrb[0];
   assign rd_pop = done & ~pwrite & (paddr == RX_HOLD_OFF);
   assign hold_wr = wr & (paddr == TX_HOLD_OFF);
   assign tx_ready = ~hold_valid_q;
   assign rx_done = (count_q != 2'h0);

   // Read mux; unmapped addresses answer zero with an error.
   always_comb begin
      hit = 1'b1;
      rd_d = 8'h00;
      unique case (paddr)
         TX_CTRL_OFF: begin
            rd_d[TXC_CLK_SRC] = clk_src_q;
            rd_d[TXC_NINTH_EN] = tx9en_q;
            rd_d[TXC_TX_EN] = tx_en_q;
            rd_d[TXC_SYNC] = sync_q;
            rd_d[TXC_TRMT] = (tx_state_q == TX_IDLE);
            rd_d[TXC_NINTH_VAL] = tx_ninth_q;
         end
         RX_CTRL_OFF: begin
            rd_d[RXC_PORT_EN] = port_en_q;
            rd_d[RXC_NINTH_EN] = rx9en_q;
            rd_d[RXC_SINGLE_EN] = single_rx_q;
            rd_d[RXC_CONT_EN] = cont_rx_q;
            rd_d[RXC_OVERRUN] = overrun_q;
            rd_d[RXC_NINTH_VAL] = fifo_q[head_q][8]; // R17
         end
         BAUD_OFF: rd_d[BAUD_RXIDLE] = (rx_cnt_q == 4'h0);
         TX_HOLD_OFF: rd_d = 8'h00;
         RX_HOLD_OFF: rd_d = fifo_q[head_q][7:0]; // R17
         INT_CTRL_OFF: begin
            rd_d[INT_TX_IE] = tx_ie_q;
            rd_d[INT_RX_IE] = rx_ie_q;
            rd_d[INT_PERIPH_IE] = periph_ie_q;
            rd_d[INT_GLOBAL_IE] = global_ie_q;
            rd_d[INT_TX_READY] = tx_ready;
            rd_d[INT_RX_DONE] = rx_done;
         end
         default: hit = 1'b0;
      endcase
   end

   // One wait state lets read data and error come from flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= access & ~pready_q;
         pslverr_q <= access & ~pready_q & ~hit;
         prdata_q <= (access & ~pready_q & ~pwrite) ? {24'h0, rd_d} : 32'h0;
      end
   end

   // Software-written control bits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_src_q <= CTRL_RESET;
         tx9en_q <= CTRL_RESET;
         tx_en_q <= CTRL_RESET;
         sync_q <= CTRL_RESET;
         tx_ninth_q <= CTRL_RESET;
         port_en_q <= CTRL_RESET;
         rx9en_q <= CTRL_RESET;
         single_rx_q <= CTRL_RESET;
         cont_rx_q <= CTRL_RESET;
         tx_ie_q <= CTRL_RESET;
         rx_ie_q <= CTRL_RESET;
         periph_ie_q <= CTRL_RESET;
         global_ie_q <= CTRL_RESET;
      end else if (wr) begin
         if (paddr == TX_CTRL_OFF) begin
            clk_src_q <= pwdata[TXC_CLK_SRC];
            tx9en_q <= pwdata[TXC_NINTH_EN];
            tx_en_q <= pwdata[TXC_TX_EN];
            sync_q <= pwdata[TXC_SYNC];
            tx_ninth_q <= pwdata[TXC_NINTH_VAL];
         end
         if (paddr == RX_CTRL_OFF) begin
            port_en_q <= pwdata[RXC_PORT_EN];
            rx9en_q <= pwdata[RXC_NINTH_EN];
            single_rx_q <= pwdata[RXC_SINGLE_EN];
            cont_rx_q <= pwdata[RXC_CONT_EN];
         end
         if (paddr == INT_CTRL_OFF) begin
            tx_ie_q <= pwdata[INT_TX_IE];
            rx_ie_q <= pwdata[INT_RX_IE];
            periph_ie_q <= pwdata[INT_PERIPH_IE];
            global_ie_q <= pwdata[INT_GLOBAL_IE];
         end
      end
   end

   // ------------------------------------------------------------------
   // Serial pin synchronisers and clock edge detection
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck_meta_q <= 1'b0;
         ck_sync_q <= 1'b0;
         ck_prev_q <= 1'b0;
         dt_meta_q <= 1'b0;
         dt_sync_q <= 1'b0;
      end else begin
         ck_meta_q <= ck_in;
         ck_sync_q <= ck_meta_q;
         ck_prev_q <= ck_sync_q;
         dt_meta_q <= dt_in;
         dt_sync_q <= dt_meta_q;
      end
   end

   logic lead, trail;
   assign lead = ck_sync_q & ~ck_prev_q;
   assign trail = ~ck_sync_q & ck_prev_q;

   // ------------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------------
   logic shift_done, load;
   assign shift_done = (tx_state_q == TX_SHIFT) & trail & (tx_cnt_q == tx_len_q);
   assign load = tx_mode & hold_valid_q & ((tx_state_q == TX_IDLE) | shift_done); // R3 R4 R12

   // Holding register; a new write wins over a simultaneous transfer out.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 8'h00;
         hold_valid_q <= 1'b0;
      end else if (hold_wr) begin
         hold_q <= pwdata[7:0]; // R16
         hold_valid_q <= 1'b1; // R13
      end else if (load || !port_en_q) begin
         hold_valid_q <= 1'b0; // R4
      end
   end

   // Shifter advances only on edges of the master's clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_q <= TX_IDLE;
         tx_shift_q <= 9'h000;
         tx_cnt_q <= 4'h0;
         tx_len_q <= BITS_PLAIN;
         dt_out_q <= 1'b0;
      end else if (!tx_mode) begin
         tx_state_q <= TX_IDLE;
         tx_cnt_q <= 4'h0;
      end else if (load) begin
         tx_state_q <= TX_SHIFT; // R3
         tx_shift_q <= {tx_ninth_q, hold_q}; // R16
         tx_len_q <= char_bits(tx9en_q); // R16
         tx_cnt_q <= 4'h0;
      end else begin
         unique case (tx_state_q)
            TX_IDLE: tx_cnt_q <= 4'h0;
            TX_SHIFT: begin
               if (lead && tx_cnt_q < tx_len_q) begin
                  dt_out_q <= tx_shift_q[0]; // R19 R21 R9
                  tx_shift_q <= {1'b0, tx_shift_q[8:1]};
                  tx_cnt_q <= tx_cnt_q + 4'h1;
               end else if (shift_done) begin
                  tx_state_q <= TX_IDLE;
               end
            end
         endcase
      end
   end

   // Pin drivers: the clock pin is never driven in slave operation.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dt_oe_q <= 1'b0;
         ck_out_q <= 1'b0;
         ck_oe_q <= 1'b0;
      end else begin
         dt_oe_q <= tx_mode;
         ck_out_q <= 1'b0;
         ck_oe_q <= 1'b0; // R18
      end
   end

   // ------------------------------------------------------------------
   // Receiver and two-character buffer
   // ------------------------------------------------------------------
   logic sample, char_done, push, overrun, pop;
   logic [8:0] rx_shift_next, word;
   logic [3:0] rx_len;
   assign rx_len = char_bits(rx9en_q);
   assign sample = rx_mode & trail & ~overrun_q; // R19 R9 R20
   assign rx_shift_next = {dt_sync_q, rx_shift_q[8:1]}; // R21
   assign char_done = sample & (rx_cnt_q == rx_len - 4'h1);
   assign word = rx9en_q ? rx_shift_next : {1'b0, rx_shift_next[8:1]}; // R17
   assign push = char_done & (count_q != FIFO_DEPTH);
   assign overrun = char_done & (count_q == FIFO_DEPTH);
   assign pop = rd_pop & rx_done;

   // Partial characters are dropped when reception is switched off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_shift_q <= 9'h000;
         rx_cnt_q <= 4'h0;
      end else if (!rx_mode) begin
         rx_cnt_q <= 4'h0;
      end else if (char_done) begin
         rx_shift_q <= 9'h000;
         rx_cnt_q <= 4'h0;
      end else if (sample) begin
         rx_shift_q <= rx_shift_next;
         rx_cnt_q <= rx_cnt_q + 4'h1;
      end
   end

   // Buffer storage; a full buffer keeps its contents on overrun.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_q[0] <= 9'h000;
         fifo_q[1] <= 9'h000;
      end else if (push) begin
         fifo_q[head_q ^ count_q[0]] <= word; // R7 R20
      end
   end

   // Occupancy and read pointer; disabling the port empties the buffer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         head_q <= 1'b0;
         count_q <= 2'h0;
      end else if (!port_en_q) begin
         head_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (pop) begin
            head_q <= ~head_q;
         end
         count_q <= count_q + {1'b0, push} - {1'b0, pop}; // R10
      end
   end

   // Overrun: a new overrun outranks a clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_q <= 1'b0;
      end else if (overrun) begin
         overrun_q <= 1'b1; // R20
      end else if (!cont_rx_q || !port_en_q) begin
         overrun_q <= 1'b0; // R15
      end
   end

   // ------------------------------------------------------------------
   // Wake-up and interrupt request to the core
   // ------------------------------------------------------------------
   logic tx_ev, rx_ev;
   assign tx_ev = tx_ready & tx_en_q & tx_ie_q;
   assign rx_ev = rx_done & rx_ie_q;

   // Flags are levels, so a sleeping core is woken however late it sleeps.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_q <= 1'b0;
         irq_q <= 1'b0;
         vector_q <= 12'h000;
      end else begin
         wake_q <= core_sleep & periph_ie_q & (tx_ev | rx_ev); // R5 R7 R10 R12
         irq_q <= global_ie_q & periph_ie_q & (tx_ev | rx_ev); // R5 R11
         vector_q <= (global_ie_q & periph_ie_q & (tx_ev | rx_ev)) ? ISR_VECTOR : 12'h000; // R11
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ck_out = ck_out_q;
   assign ck_oe = ck_oe_q;
   assign dt_out = dt_out_q;
   assign dt_oe = dt_oe_q;
   assign wake = wake_q;
   assign irq = irq_q;
   assign irq_vector = vector_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_ck_undriven;
      @(posedge pclk) disable iff (!presetn) !ck_oe;
   endproperty
   a_ck_undriven: assert property (p_ck_undriven) else $error("clock pin driven"); // R18

   property p_dt_drive_mode;
      @(posedge pclk) disable iff (!presetn)
         dt_oe |-> $past(sync_q & ~clk_src_q & port_en_q & ~single_rx_q & ~cont_rx_q);
   endproperty
   a_dt_drive_mode: assert property (p_dt_drive_mode) else $error("data driven outside tx"); // R1

   property p_write_clears_ready;
      @(posedge pclk) disable iff (!presetn) hold_wr |=> !tx_ready;
   endproperty
   a_write_clears_ready: assert property (p_write_clears_ready)
      else $error("transmit ready stays set"); // R13

   // Only a shifter still in transmit mode may reload from the holding register.
   sequence s_shift_end_pending;
      shift_done && tx_mode && hold_valid_q && !hold_wr;
   endsequence
   property p_reload;
      @(posedge pclk) disable iff (!presetn)
         s_shift_end_pending |=> (tx_state_q == TX_SHIFT) && tx_ready && tx_cnt_q == 4'h0;
   endproperty
   a_reload: assert property (p_reload) else $error("no reload after shift"); // R4

   property p_overrun;
      @(posedge pclk) disable iff (!presetn)
         overrun && !pop |=> overrun_q && count_q == FIFO_DEPTH && $stable(fifo_q[0])
            && $stable(fifo_q[1]);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun mishandled"); // R20

   property p_overrun_clear;
      @(posedge pclk) disable iff (!presetn) (!cont_rx_q && !overrun) |=> !overrun_q;
   endproperty
   a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared"); // R15

   property p_rx_done_set;
      @(posedge pclk) disable iff (!presetn) push && port_en_q |=> rx_done;
   endproperty
   a_rx_done_set: assert property (p_rx_done_set) else $error("receive flag missed"); // R10

   sequence s_tx_wake_cause;
      core_sleep && periph_ie_q && tx_ie_q && tx_en_q && tx_ready;
   endsequence
   property p_tx_wake;
      @(posedge pclk) disable iff (!presetn) s_tx_wake_cause |=> wake;
   endproperty
   a_tx_wake: assert property (p_tx_wake) else $error("no wake on transmit ready"); // R5

   property p_vector;
      @(posedge pclk) disable iff (!presetn) irq |-> irq_vector == ISR_VECTOR;
   endproperty
   a_vector: assert property (p_vector) else $error("wrong vector"); // R11

   property p_no_shift_without_edge;
      @(posedge pclk) disable iff (!presetn)
         (!trail && rx_mode) |=> $stable(rx_cnt_q) || rx_cnt_q == 4'h0;
   endproperty
   a_no_shift_without_edge: assert property (p_no_shift_without_edge)
      else $error("rx shifted without clock"); // R9

endmodule // sync_slave_serial_port

//--- bench/sync_master_model.sv
// Purpose: Behavioural external master that clocks the slave serial port.
// Assumes: Clock idles low; rising edge leads, falling edge trails.
// Notes: Each bit lasts 8 pclk cycles, 5 high and 3 low, a 320 ns period.

module sync_master_model (
   input wire logic pclk,
   input wire logic dt_wire,
   output logic ck,
   output logic dt
);
   timeunit 1ns;
   timeprecision 1ps;

   // Clock rests low outside frames; data starts high.
   initial begin
      ck = 1'b0;
      dt = 1'b1;
   end

   // -----------------------------------------------------------------
   // One frame of exactly nbits clocks, LSB first, ninth bit last.
   // -----------------------------------------------------------------
   task automatic frame(input logic [8:0] tx, input int nbits, output logic [8:0] rx);
      rx = 9'h000;
      for (int i = 0; i < nbits; i++) begin
         @(posedge pclk);
         ck <= 1'b1;
         dt <= tx[i];
         repeat (5) @(posedge pclk);
         rx[i] = dt_wire;
         ck <= 1'b0;
         repeat (2) @(posedge pclk);
      end
      // The line is then driven to the inverse of the last bit.
      @(posedge pclk);
      dt <= ~dt;
   endtask
endmodule // sync_master_model

//--- bench/sync_slave_serial_port_tb_top.sv
// Purpose: Self-checking bench for the synchronous slave serial port.
// Assumes: APB answers with one wait state; the master model drives the link.
// Notes: Each scenario is a task that configures, drives and judges.

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end

module sync_slave_serial_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sync_slave_pkg::*;

   logic pclk, presetn, psel, penable, pwrite, core_sleep;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0] pstrb;
   logic pready, pslverr, erv, ck_out, ck_oe, dt_out, dt_oe, wake, irq;
   logic m_ck, m_dt, ck_w, dt_w;
   logic [11:0] irq_vector;
   logic [8:0] rxv;
   int err_total, comparisons, cyc;

   // -----------------------------------------------------------------
   // Clock, pin resolution and instances
   // -----------------------------------------------------------------
   always #20 pclk = ~pclk;

   // Each shared pin carries whichever party has its driver enabled.
   assign ck_w = ck_oe ? ck_out : m_ck;
   assign dt_w = dt_oe ? dt_out : m_dt;

   sync_slave_serial_port u_sync_slave_serial_port (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ck_in(ck_w), .ck_out(ck_out), .ck_oe(ck_oe), .dt_in(dt_w),
      .dt_out(dt_out), .dt_oe(dt_oe), .core_sleep(core_sleep),
      .wake(wake), .irq(irq), .irq_vector(irq_vector)
   );

   sync_master_model master (
      .pclk(pclk), .dt_wire(dt_w), .ck(m_ck), .dt(m_dt)
   );

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   // One APB transfer; the request is held until pready is sampled.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_total++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Bounded wait for a level output to rise, then judged by the caller.
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset_map;
      apb(1'b0, TX_CTRL_OFF, 32'h0, rdv, erv);
      // The shifter-idle status bit reads one while nothing is being sent.
      `CHK("tx_ctrl reset", 32'h00000002, rdv)
      `CHK("mapped err", 1'b0, erv)
      apb(1'b0, RX_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("rx_ctrl reset", 32'h00000000, rdv)
      apb(1'b0, INT_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("int_ctrl reset", 32'h00000010, rdv)
      apb(1'b0, 8'h18, 32'h0, rdv, erv);
      `CHK("unmapped err", 1'b1, erv)
      `CHK("unmapped data", 32'h00000000, rdv)
      apb(1'b0, BAUD_OFF, 32'h0, rdv, erv);
      `CHK("rx idle", 32'h00000040, rdv)
      // A write without its low byte strobe must leave the register alone.
      pstrb <= 4'h0;
      apb(1'b1, INT_CTRL_OFF, 32'h0f, rdv, erv);
      pstrb <= 4'hf;
      apb(1'b0, INT_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("strobe refused", 32'h00000010, rdv)
      `CHK("ck_oe", 1'b0, ck_oe)
      `CHK("ck_out", 1'b0, ck_out)
      `CHK("vector idle", 12'h000, irq_vector)
      $display("test reset_map done");
   endtask

   // Two characters queued, then sent while the core sleeps.
   task automatic t_tx_sleep;
      apb(1'b1, TX_CTRL_OFF, 32'h30, rdv, erv);
      apb(1'b1, RX_CTRL_OFF, 32'h80, rdv, erv);
      apb(1'b1, INT_CTRL_OFF, 32'h05, rdv, erv);
      apb(1'b1, TX_HOLD_OFF, 32'ha5, rdv, erv);
      apb(1'b1, TX_HOLD_OFF, 32'h3c, rdv, erv);
      `CHK("dt_oe tx", 1'b1, dt_oe)
      apb(1'b0, INT_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("transmit_ready_flag after two", 32'h00000005, rdv)
      core_sleep <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK("wake early", 1'b0, wake)
      master.frame(9'h000, 8, rxv);
      `CHK("first char", 8'ha5, rxv[7:0])
      wait_hi(wake);
      `CHK("wake tx", 1'b1, wake)
      `CHK("irq no gie", 1'b0, irq)
      apb(1'b0, INT_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("transmit_ready_flag reload", 32'h00000015, rdv)
      apb(1'b1, INT_CTRL_OFF, 32'h0d, rdv, erv);
      wait_hi(irq);
      `CHK("irq gie", 1'b1, irq)
      `CHK("vector", 12'h004, irq_vector)
      master.frame(9'h000, 8, rxv);
      `CHK("second char", 8'h3c, rxv[7:0])
      apb(1'b1, TX_CTRL_OFF, 32'h71, rdv, erv);
      apb(1'b1, TX_HOLD_OFF, 32'h5a, rdv, erv);
      master.frame(9'h000, 9, rxv);
      `CHK("ninth tx", 9'h15a, rxv)
      core_sleep <= 1'b0;
      apb(1'b1, INT_CTRL_OFF, 32'h00, rdv, erv);
      $display("test tx_sleep done");
   endtask

   // Sleep reception, then a third character that overruns.
   task automatic t_rx_sleep;
      apb(1'b1, TX_CTRL_OFF, 32'h10, rdv, erv);
      apb(1'b1, RX_CTRL_OFF, 32'hf0, rdv, erv);
      apb(1'b1, INT_CTRL_OFF, 32'h06, rdv, erv);
      `CHK("dt_oe rx", 1'b0, dt_oe)
      `CHK("ck_oe rx", 1'b0, ck_oe)
      // Software empties the buffer before it sleeps.
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, RX_HOLD_OFF, 32'h0, rdv, erv);
      end
      core_sleep <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK("wake idle", 1'b0, wake)
      master.frame(9'h196, 9, rxv);
      wait_hi(wake);
      `CHK("wake rx", 1'b1, wake)
      apb(1'b0, INT_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("receive_complete_flag", 32'h00000036, rdv)
      apb(1'b0, RX_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("received_ninth_bit", 32'h000000f1, rdv)
      apb(1'b0, RX_HOLD_OFF, 32'h0, rdv, erv);
      `CHK("rx data", 32'h00000096, rdv)
      core_sleep <= 1'b0;
      master.frame(9'h011, 9, rxv);
      master.frame(9'h122, 9, rxv);
      master.frame(9'h033, 9, rxv);
      apb(1'b0, RX_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("overrun", 32'h000000f2, rdv)
      apb(1'b0, RX_HOLD_OFF, 32'h0, rdv, erv);
      `CHK("fifo first", 32'h00000011, rdv)
      apb(1'b0, RX_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("received_ninth_bit second", 32'h000000f3, rdv)
      apb(1'b0, RX_HOLD_OFF, 32'h0, rdv, erv);
      `CHK("fifo second", 32'h00000022, rdv)
      apb(1'b0, INT_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("third dropped", 32'h00000016, rdv)
      apb(1'b1, RX_CTRL_OFF, 32'he0, rdv, erv);
      apb(1'b0, RX_CTRL_OFF, 32'h0, rdv, erv);
      `CHK("overrun cleared", 32'h000000e0, rdv)
      $display("test rx_sleep done");
   endtask

   // -----------------------------------------------------------------
   // Main sequence and hang guard
   // -----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      core_sleep = 1'b0;
      err_total = 0;
      comparisons = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_map();
      t_tx_sleep();
      t_rx_sleep();
      tally_and_finish();
   end

   // The whole run needs under 2000 cycles; 6000 means a hang.
   initial cyc = 0;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         tally_and_finish();
      end
   end
endmodule // sync_slave_serial_port_tb_top
